// ===== rtl/pcsr_consts.vh
// Summary of operation
// - Compare full 16-bit field length against scratch length continuously.
// - Condition nibble: bit3 equal, bit2 greater, bit1 less, bit0 nonzero.
// - Every memory access checks field address against base and limit, flags it.
// - Out-of-bounds write or swap write suppressed unless override bit 2 set.
// - Overridden out-of-bounds write still sets write flag bit 0.
// - Reads always proceed; out-of-bounds read sets flag bit 1.
// - Only starting field address is bounds checked.
// - 24-bit control word in three bytes; top byte two general nibbles.
// - State nibble: console, I/O request, timer interrupts, console state bit.
// - Console switch and I/O service request set their interrupt bits.
// - Timer sets its bit every 100 ms; stays until software clears.
// - A memory parity error during a read, write or swap access sets fault bit 3.
// - Interrupt bits trigger nothing automatically.
// - Low control byte: carry flag, 2-bit unit type, 5-bit operand length.
// - Reading control byte zero-extends; writing takes low eight bits.
// - Unit type is write-only; 00 binary, 01 decimal, 11 eight-bit.
// - Main and control memory size registers are read-only configuration.
// - Cassette register read only by register move; stalls until data.
// - I/O data port reads and writes 24 bits to selected controller.
// - Command port is write-only, forwards 24-bit command.
// - Zero source always reads zero.
// - Function results recompute immediately from operands and control byte.
// - Carry flag is the high bit of the control byte.
`ifndef PCSR_CONSTS_VH
`define PCSR_CONSTS_VH
`define PCSR_SEL_COND 4'h0
`define PCSR_SEL_CTRL 4'h1
`define PCSR_SEL_GEN_A 4'h2
`define PCSR_SEL_GEN_B 4'h3
`define PCSR_SEL_STATE 4'h4
`define PCSR_SEL_FAULT 4'h5
`define PCSR_SEL_ARITH 4'h6
`define PCSR_SEL_MSIZE 4'h7
`define PCSR_SEL_CSIZE 4'h8
`define PCSR_SEL_TAPE 4'h9
`define PCSR_SEL_DATA 4'ha
`define PCSR_SEL_IO_COMMAND_PORT 4'hb
`define PCSR_SEL_ZERO 4'hc
`define PCSR_SEL_X 4'hd
`define PCSR_SEL_Y 4'he
`define PCSR_SEL_BASE 4'hf
`define PCSR_BIT_CON_INT 0
`define PCSR_BIT_IO_INT 1
`define PCSR_BIT_TMR_INT 2
`define PCSR_BIT_CON_STATE 3
`define PCSR_BIT_WR_OOB 0
`define PCSR_BIT_RD_OOB 1
`define PCSR_BIT_OVERRIDE 2
`define PCSR_BIT_PARITY 3
`define PCSR_BIT_CARRY 7
`define PCSR_UNIT_HI 6
`define PCSR_UNIT_LO 5
`define PCSR_LEN_HI 4
`define PCSR_UNIT_BIN 2'h0
`define PCSR_UNIT_DEC4 2'h1
`define PCSR_UNIT_NUM8 2'h3
`define PCSR_TIMER_MS 100
`define PCSR_CLK_MHZ 100
`define PCSR_TIMER_CYC (`PCSR_TIMER_MS * 1000 * `PCSR_CLK_MHZ)
`define PCSR_RST_NIBBLE 4'h0
`define PCSR_RST_BYTE 8'h00
`define PCSR_RST_WORD 24'h000000
`endif

// ===== rtl/pcsr_regs.v
`timescale 1ns/1ps
`include "pcsr_consts.vh"
module pcsr_regs #(
  parameter TIMER_CYCLES = `PCSR_TIMER_CYC,
  parameter [23:0] MAIN_MEM_SIZE = 24'h000000,
  parameter [23:0] CTRL_MEM_SIZE = 24'h000000
) (
  // Clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // Register move port
  input wire [3:0] RD_SEL,
  input wire RD_EN,
  input wire RD_IS_MOVE,
  output reg [23:0] RD_DATA,
  output wire RD_STALL,
  input wire [3:0] WR_SEL,
  input wire WR_EN,
  input wire [23:0] WR_DATA,
  input wire LIMIT_WR_EN,
  // Field descriptor inputs
  input wire [15:0] FIELD_LENGTH,
  input wire [15:0] SCRATCH_WORD0_RIGHT,
  input wire [23:0] FIELD_ADDRESS,
  output wire [3:0] LENGTH_CONDITION_BITS,
  // Main memory access
  input wire MEM_RD_REQ,
  input wire MEM_WR_REQ,
  input wire MEM_SWAP_REQ,
  input wire MEM_PARITY_ERR,
  output wire MEM_WR_ALLOW,
  // Interrupt sources
  input wire CONSOLE_SWITCH,
  input wire IO_SERVICE_REQ,
  output wire [3:0] PROCESSOR_STATE_BITS,
  output wire [3:0] MEMORY_FAULT_BITS,
  // Cassette input
  input wire TAPE_VALID,
  input wire [15:0] TAPE_DATA,
  // I/O controller
  input wire [23:0] IO_RD_DATA,
  output wire IO_DATA_RD,
  output reg IO_DATA_WR,
  output reg IO_CMD_WR,
  output reg [23:0] IO_WR_DATA,
  // Function box
  output wire [23:0] AND_RESULT,
  output wire [23:0] OR_RESULT,
  output wire [23:0] XOR_RESULT,
  output wire [23:0] CMPX_RESULT,
  output wire [23:0] CMPY_RESULT,
  output wire CARRY_FLAG,
  output wire [1:0] UNIT_TYPE,
  output wire [4:0] OPERAND_LENGTH
);
  reg [3:0] general_nibble_a;
  reg [3:0] general_nibble_b;
  reg [3:0] proc_state;
  reg [3:0] mem_fault;
  reg [7:0] arith_control_byte;
  reg [23:0] base_bound;
  reg [23:0] limit_bound;
  reg [23:0] x_op;
  reg [23:0] y_op;
  reg [15:0] tape_hold;
  reg tape_full;
  reg [31:0] timer_cnt;
  reg con_s1, con_s2, io_s1, io_s2, tv_s1, tv_s2;
  reg tv_s3;
  reg [15:0] td_s1, td_s2;
  wire timer_tick;
  wire out_of_bounds;
  wire wr_access;
  wire wr_state;
  wire wr_fault;
  wire wr_ctrl;
  reg [23:0] len_mask;
  integer i;

  // Length comparison
  assign LENGTH_CONDITION_BITS = {FIELD_LENGTH == SCRATCH_WORD0_RIGHT, FIELD_LENGTH > SCRATCH_WORD0_RIGHT,
                                  FIELD_LENGTH < SCRATCH_WORD0_RIGHT, FIELD_LENGTH != 16'h0000};

  // Bounds check on starting address only
  assign out_of_bounds = (FIELD_ADDRESS < base_bound) || (FIELD_ADDRESS > limit_bound);
  assign wr_access = MEM_WR_REQ | MEM_SWAP_REQ;
  assign MEM_WR_ALLOW = wr_access & (~out_of_bounds | mem_fault[`PCSR_BIT_OVERRIDE]);

  // Input synchronisers
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      con_s1 <= 1'b0;
      con_s2 <= 1'b0;
      io_s1 <= 1'b0;
      io_s2 <= 1'b0;
      tv_s1 <= 1'b0;
      tv_s2 <= 1'b0;
      tv_s3 <= 1'b0;
      td_s1 <= 16'h0000;
      td_s2 <= 16'h0000;
    end else begin
      con_s1 <= CONSOLE_SWITCH;
      con_s2 <= con_s1;
      io_s1 <= IO_SERVICE_REQ;
      io_s2 <= io_s1;
      tv_s1 <= TAPE_VALID;
      tv_s2 <= tv_s1;
      tv_s3 <= tv_s2;
      td_s1 <= TAPE_DATA;
      td_s2 <= td_s1;
    end
  end

  // Interval timer
  assign timer_tick = (timer_cnt == TIMER_CYCLES - 1);
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      timer_cnt <= 32'h00000000;
    end else if (timer_tick) begin
      timer_cnt <= 32'h00000000;
    end else begin
      timer_cnt <= timer_cnt + 32'h00000001;
    end
  end

  assign wr_ctrl = WR_EN && (WR_SEL == `PCSR_SEL_CTRL);
  assign wr_state = WR_EN && (WR_SEL == `PCSR_SEL_STATE);
  assign wr_fault = WR_EN && (WR_SEL == `PCSR_SEL_FAULT);

  // Control word storage; hardware set wins over software clear
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      general_nibble_a <= `PCSR_RST_NIBBLE;
      general_nibble_b <= `PCSR_RST_NIBBLE;
      proc_state <= `PCSR_RST_NIBBLE;
      mem_fault <= `PCSR_RST_NIBBLE;
      arith_control_byte <= `PCSR_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        general_nibble_a <= WR_DATA[23:20];
        general_nibble_b <= WR_DATA[19:16];
        arith_control_byte <= WR_DATA[7:0];
      end
      if (WR_EN && WR_SEL == `PCSR_SEL_GEN_A)
        general_nibble_a <= WR_DATA[3:0];
      if (WR_EN && WR_SEL == `PCSR_SEL_GEN_B)
        general_nibble_b <= WR_DATA[3:0];
      if (WR_EN && WR_SEL == `PCSR_SEL_ARITH)
        arith_control_byte <= WR_DATA[7:0];
      proc_state <= (wr_state ? WR_DATA[3:0] : (wr_ctrl ? WR_DATA[15:12] : proc_state))
                    | {1'b0, timer_tick, io_s2, con_s2};
      mem_fault <= (wr_fault ? WR_DATA[3:0] : (wr_ctrl ? WR_DATA[11:8] : mem_fault))
                   | {MEM_PARITY_ERR & (MEM_RD_REQ | wr_access), 1'b0,
                      MEM_RD_REQ & out_of_bounds, wr_access & out_of_bounds};
    end
  end

  // Bounds, operands, I/O writes
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      base_bound <= `PCSR_RST_WORD;
      limit_bound <= `PCSR_RST_WORD;
      x_op <= `PCSR_RST_WORD;
      y_op <= `PCSR_RST_WORD;
      IO_DATA_WR <= 1'b0;
      IO_CMD_WR <= 1'b0;
      IO_WR_DATA <= `PCSR_RST_WORD;
    end else begin
      IO_DATA_WR <= WR_EN && (WR_SEL == `PCSR_SEL_DATA);
      IO_CMD_WR <= WR_EN && (WR_SEL == `PCSR_SEL_IO_COMMAND_PORT);
      if (WR_EN && (WR_SEL == `PCSR_SEL_DATA || WR_SEL == `PCSR_SEL_IO_COMMAND_PORT))
        IO_WR_DATA <= WR_DATA;
      if (WR_EN && WR_SEL == `PCSR_SEL_BASE)
        base_bound <= WR_DATA;
      if (LIMIT_WR_EN)
        limit_bound <= WR_DATA;
      if (WR_EN && WR_SEL == `PCSR_SEL_X)
        x_op <= WR_DATA;
      if (WR_EN && WR_SEL == `PCSR_SEL_Y)
        y_op <= WR_DATA;
    end
  end

  // Cassette holding register; one word per rising valid, so a long valid is not taken twice
  assign RD_STALL = RD_EN && RD_IS_MOVE && (RD_SEL == `PCSR_SEL_TAPE) && !tape_full;
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tape_hold <= 16'h0000;
      tape_full <= 1'b0;
    end else if (tv_s2 && !tv_s3) begin
      tape_hold <= td_s2;
      tape_full <= 1'b1;
    end else if (RD_EN && RD_IS_MOVE && RD_SEL == `PCSR_SEL_TAPE && tape_full) begin
      tape_full <= 1'b0;
    end
  end

  // Function box
  assign CARRY_FLAG = arith_control_byte[`PCSR_BIT_CARRY];
  assign UNIT_TYPE = arith_control_byte[`PCSR_UNIT_HI:`PCSR_UNIT_LO];
  assign OPERAND_LENGTH = arith_control_byte[`PCSR_LEN_HI:0];
  always @* begin
    len_mask = 24'h000000;
    for (i = 0; i < 24; i = i + 1)
      len_mask[i] = (i < OPERAND_LENGTH);
  end
  assign AND_RESULT = x_op & y_op & len_mask;
  assign OR_RESULT = (x_op | y_op) & len_mask;
  assign XOR_RESULT = (x_op ^ y_op) & len_mask;
  assign CMPX_RESULT = ~x_op & len_mask;
  assign CMPY_RESULT = ~y_op & len_mask;

  // Read mux
  assign IO_DATA_RD = RD_EN && (RD_SEL == `PCSR_SEL_DATA);
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= `PCSR_RST_WORD;
    end else if (RD_EN && !RD_STALL) begin
      case (RD_SEL)
        `PCSR_SEL_COND: RD_DATA <= {20'h00000, LENGTH_CONDITION_BITS};
        `PCSR_SEL_CTRL: RD_DATA <= {general_nibble_a, general_nibble_b, proc_state, mem_fault,
                                    arith_control_byte[7], 2'h0, arith_control_byte[4:0]};
        `PCSR_SEL_GEN_A: RD_DATA <= {20'h00000, general_nibble_a};
        `PCSR_SEL_GEN_B: RD_DATA <= {20'h00000, general_nibble_b};
        `PCSR_SEL_STATE: RD_DATA <= {20'h00000, proc_state};
        `PCSR_SEL_FAULT: RD_DATA <= {20'h00000, mem_fault};
        `PCSR_SEL_ARITH: RD_DATA <= {16'h0000, arith_control_byte[7], 2'h0, arith_control_byte[4:0]};
        `PCSR_SEL_MSIZE: RD_DATA <= MAIN_MEM_SIZE;
        `PCSR_SEL_CSIZE: RD_DATA <= CTRL_MEM_SIZE;
        `PCSR_SEL_TAPE: RD_DATA <= RD_IS_MOVE ? {8'h00, tape_hold} : 24'h000000;
        `PCSR_SEL_DATA: RD_DATA <= IO_RD_DATA;
        `PCSR_SEL_X: RD_DATA <= x_op;
        `PCSR_SEL_Y: RD_DATA <= y_op;
        `PCSR_SEL_BASE: RD_DATA <= base_bound;
        default: RD_DATA <= 24'h000000;
      endcase
    end
  end

  assign PROCESSOR_STATE_BITS = proc_state;
  assign MEMORY_FAULT_BITS = mem_fault;
endmodule

// ===== dv/pcsr_far_end.sv
`timescale 1ns/1ps
module pcsr_far_end #(
  parameter [23:0] DATA_WORD = 24'h5a3c96
) (
  // Clock
  input wire clk,
  // I/O controller side
  input wire io_data_rd,
  output wire [23:0] io_rd_data,
  // Cassette side
  input wire tape_go,
  input wire [15:0] tape_word,
  output reg tape_valid = 1'b0,
  output reg [15:0] tape_data = 16'h0000
);
  reg [2:0] hold = 3'd0;
  // Word only while selected, inverse when released
  assign io_rd_data = io_data_rd ? DATA_WORD : ~DATA_WORD;
  // Data first, valid two cycles later for four cycles
  always @(posedge clk) begin
    tape_valid <= hold > 3'd1 && hold < 3'd6;
    if (tape_go) begin
      hold <= 3'd6;
      tape_data <= tape_word;
    end else if (hold != 3'd0) begin
      hold <= hold - 3'd1;
    end else begin
      tape_data <= ~tape_data;
    end
  end
endmodule

// ===== dv/pcsr_regs_sva.sv
`timescale 1ns/1ps
module pcsr_regs_sva (
  // Clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // Register port
  input wire [3:0] RD_SEL,
  input wire RD_EN,
  input wire [23:0] RD_DATA,
  input wire RD_STALL,
  input wire [3:0] WR_SEL,
  input wire WR_EN,
  input wire [23:0] WR_DATA,
  input wire LIMIT_WR_EN,
  // Field and memory
  input wire [15:0] FIELD_LENGTH,
  input wire [15:0] SCRATCH_WORD0_RIGHT,
  input wire [23:0] FIELD_ADDRESS,
  input wire [3:0] LENGTH_CONDITION_BITS,
  input wire MEM_RD_REQ,
  input wire MEM_WR_REQ,
  input wire MEM_SWAP_REQ,
  input wire MEM_PARITY_ERR,
  input wire MEM_WR_ALLOW,
  input wire [3:0] MEMORY_FAULT_BITS,
  // Outputs
  input wire IO_CMD_WR,
  input wire [23:0] IO_WR_DATA,
  input wire [23:0] AND_RESULT,
  input wire CARRY_FLAG,
  input wire [4:0] OPERAND_LENGTH
);
  reg [23:0] base, limit, x, y;
  wire oob = FIELD_ADDRESS < base || FIELD_ADDRESS > limit;
  wire wrq = MEM_WR_REQ || MEM_SWAP_REQ;
  wire [23:0] msk = OPERAND_LENGTH >= 5'd24 ? 24'hffffff : (24'h000001 << OPERAND_LENGTH) - 24'h000001;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Shadow bounds and operands
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      {base, limit, x, y} <= 96'h0;
    end else begin
      if (WR_EN && WR_SEL == 4'hf) base <= WR_DATA;
      if (LIMIT_WR_EN) limit <= WR_DATA;
      if (WR_EN && WR_SEL == 4'hd) x <= WR_DATA;
      if (WR_EN && WR_SEL == 4'he) y <= WR_DATA;
    end
  end
  a_cond_bits:
    assert property (LENGTH_CONDITION_BITS == {FIELD_LENGTH == SCRATCH_WORD0_RIGHT,
      FIELD_LENGTH > SCRATCH_WORD0_RIGHT, FIELD_LENGTH < SCRATCH_WORD0_RIGHT, FIELD_LENGTH != 16'h0000})
      else $error("cond bits");
  a_write_allow:
    assert property (wrq |-> MEM_WR_ALLOW == (!oob || MEMORY_FAULT_BITS[2])) else $error("write allow");
  a_write_flag:
    assert property (wrq && oob |=> MEMORY_FAULT_BITS[0]) else $error("write flag");
  a_read_flag:
    assert property (MEM_RD_REQ && oob |=> MEMORY_FAULT_BITS[1]) else $error("read flag");
  a_parity_flag:
    assert property (MEM_PARITY_ERR && (MEM_RD_REQ || wrq) |=> MEMORY_FAULT_BITS[3]) else $error("parity");
  a_arith_read:
    assert property (RD_EN && !RD_STALL && RD_SEL == 4'h6 |=>
      RD_DATA == {16'h0000, $past(CARRY_FLAG), 2'b00, $past(OPERAND_LENGTH)}) else $error("arith read");
  a_zero_read:
    assert property (RD_EN && !RD_STALL && RD_SEL == 4'hc |=> RD_DATA == 24'h000000) else $error("zero");
  a_cmd_out:
    assert property (WR_EN && WR_SEL == 4'hb |=> IO_CMD_WR && IO_WR_DATA == $past(WR_DATA)) else $error("cmd");
  a_stall_cause:
    assert property (RD_STALL |-> RD_EN && RD_SEL == 4'h9) else $error("stall");
  a_func_box:
    assert property (AND_RESULT == (x & y & msk)) else $error("and result");
endmodule
bind pcsr_regs pcsr_regs_sva chk (.*);

// ===== dv/pcsr_regs_tb.sv
`timescale 1ns/1ps
module pcsr_regs_tb;
  reg REF_CLK = 1'b0, RST_N = 1'b0, RD_EN = 1'b0, WR_EN = 1'b0, LIMIT_WR_EN = 1'b0;
  reg CONSOLE_SWITCH = 1'b0, IO_SERVICE_REQ = 1'b0, tape_go = 1'b0, RD_IS_MOVE = 1'b1;
  reg [3:0] RD_SEL = 4'h0, WR_SEL = 4'h0, mreq = 4'h0;
  reg [23:0] WR_DATA = 24'h0, FIELD_ADDRESS = 24'h0;
  reg [15:0] FIELD_LENGTH = 16'h0, SCRATCH_WORD0_RIGHT = 16'h0;
  wire [23:0] RD_DATA, IO_RD_DATA, IO_WR_DATA, AND_RESULT;
  wire [15:0] TAPE_DATA;
  wire [3:0] LENGTH_CONDITION_BITS, PROCESSOR_STATE_BITS, MEMORY_FAULT_BITS;
  wire [4:0] OPERAND_LENGTH;
  wire [1:0] UNIT_TYPE;
  wire RD_STALL, MEM_WR_ALLOW, TAPE_VALID, IO_DATA_RD, IO_DATA_WR, IO_CMD_WR, CARRY_FLAG;
  integer err_total = 0, total_checks = 0, i;
  reg al;
  // Field length, scratch length, condition nibble
  reg [35:0] rows [0:5] = '{36'h000500059, 36'h000700035, 36'h000200093, 36'h000000008,
    36'hfffffffe5, 36'h000000012};
  pcsr_regs #(.TIMER_CYCLES(50), .MAIN_MEM_SIZE(24'h010000), .CTRL_MEM_SIZE(24'h001000)) dut (.*,
    .MEM_RD_REQ(mreq[3]), .MEM_WR_REQ(mreq[2]), .MEM_SWAP_REQ(mreq[1]),
    .MEM_PARITY_ERR(mreq[0]), .OR_RESULT(), .XOR_RESULT(), .CMPX_RESULT(), .CMPY_RESULT());
  pcsr_far_end far (.clk(REF_CLK), .io_data_rd(IO_DATA_RD), .io_rd_data(IO_RD_DATA), .tape_go(tape_go),
    .tape_word(16'hc3a5), .tape_valid(TAPE_VALID), .tape_data(TAPE_DATA));
  task chk(input string what, input [23:0] exp, input [23:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task wr(input [3:0] s, input [23:0] d, input lim);
    begin
      @(posedge REF_CLK);
      WR_SEL <= s;
      WR_DATA <= d;
      WR_EN <= !lim;
      LIMIT_WR_EN <= lim;
      @(posedge REF_CLK);
      WR_EN <= 1'b0;
      LIMIT_WR_EN <= 1'b0;
      #1;
    end
  endtask
  task rd(input [3:0] s);
    begin
      @(posedge REF_CLK);
      RD_SEL <= s;
      RD_EN <= 1'b1;
      @(negedge REF_CLK);
      while (RD_STALL !== 1'b0) @(negedge REF_CLK);
      @(posedge REF_CLK);
      RD_EN <= 1'b0;
      #1;
    end
  endtask
  task mem(input [23:0] a, input [3:0] q);
    begin
      @(posedge REF_CLK);
      FIELD_ADDRESS <= a;
      mreq <= q;
      @(negedge REF_CLK);
      al = MEM_WR_ALLOW;
      @(posedge REF_CLK);
      mreq <= 4'h0;
      #1;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    forever #5 REF_CLK = ~REF_CLK;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    #1;
    chk("fault", 24'h0, {20'h0, MEMORY_FAULT_BITS});
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge REF_CLK);
      {FIELD_LENGTH, SCRATCH_WORD0_RIGHT} <= rows[i][35:4];
      @(negedge REF_CLK);
      chk("cond", {20'h0, rows[i][3:0]}, {20'h0, LENGTH_CONDITION_BITS});
    end
    wr(4'h1, 24'ha50498, 1'b0);
    rd(4'h1);
    chk("ctrl", 24'ha50498, RD_DATA & 24'hff0fff);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h6, {16'hffff, 1'b0, i[1:0], 5'd24}, 1'b0);
      chk("unit", {22'h0, i[1:0]}, {22'h0, UNIT_TYPE});
      rd(4'h6);
      chk("arith", 24'h000018, RD_DATA);
    end
    wr(4'hd, 24'hf0f0f0, 1'b0);
    wr(4'he, 24'hff00ff, 1'b0);
    wr(4'h6, 24'h000008, 1'b0);
    chk("and8", 24'h0000f0, AND_RESULT);
    wr(4'h6, 24'h000098, 1'b0);
    chk("and24", 24'hf000f0, AND_RESULT);
    chk("carry", 24'h1, {23'h0, CARRY_FLAG});
    wr(4'hf, 24'h000100, 1'b0);
    wr(4'h0, 24'h000200, 1'b1);
    wr(4'h5, 24'h000000, 1'b0);
    mem(24'h000050, 4'h4);
    chk("allow", 24'h0, {23'h0, al});
    chk("fault", 24'h1, {20'h0, MEMORY_FAULT_BITS});
    mem(24'h000050, 4'h8);
    chk("fault", 24'h3, {20'h0, MEMORY_FAULT_BITS});
    wr(4'h5, 24'h000004, 1'b0);
    mem(24'h000300, 4'h2);
    chk("allow", 24'h1, {23'h0, al});
    chk("fault", 24'h5, {20'h0, MEMORY_FAULT_BITS});
    wr(4'h5, 24'h000000, 1'b0);
    mem(24'h000150, 4'h5);
    chk("allow", 24'h1, {23'h0, al});
    chk("fault", 24'h8, {20'h0, MEMORY_FAULT_BITS});
    wr(4'hb, 24'habcdef, 1'b0);
    chk("cmd", 24'habcdef, IO_CMD_WR ? IO_WR_DATA : 24'h0);
    wr(4'ha, 24'h123456, 1'b0);
    chk("data", 24'h123456, IO_DATA_WR ? IO_WR_DATA : 24'h0);
    rd(4'ha);
    chk("io rd", 24'h5a3c96, RD_DATA);
    rd(4'h7);
    chk("msize", 24'h010000, RD_DATA);
    rd(4'h8);
    chk("csize", 24'h001000, RD_DATA);
    rd(4'hc);
    chk("zero", 24'h0, RD_DATA);
    fork
      rd(4'h9);
      begin
        repeat (5) @(negedge REF_CLK);
        chk("stall", 24'h1, {23'h0, RD_STALL});
        @(posedge REF_CLK);
        tape_go <= 1'b1;
        @(posedge REF_CLK);
        tape_go <= 1'b0;
      end
    join
    chk("tape", 24'h00c3a5, RD_DATA);
    repeat (8) @(posedge REF_CLK);
    RD_SEL <= 4'h9;
    RD_EN <= 1'b1;
    @(negedge REF_CLK);
    chk("refill", 24'h1, {23'h0, RD_STALL});
    @(posedge REF_CLK);
    RD_EN <= 1'b0;
    RD_IS_MOVE <= 1'b0;
    rd(4'h9);
    chk("nomove", 24'h0, RD_DATA);
    RD_IS_MOVE <= 1'b1;
    wr(4'h4, 24'h000000, 1'b0);
    @(posedge REF_CLK);
    CONSOLE_SWITCH <= 1'b1;
    IO_SERVICE_REQ <= 1'b1;
    repeat (4) @(posedge REF_CLK);
    CONSOLE_SWITCH <= 1'b0;
    IO_SERVICE_REQ <= 1'b0;
    repeat (4) @(posedge REF_CLK);
    #1;
    chk("state", 24'h3, {22'h0, PROCESSOR_STATE_BITS[1:0]});
    wr(4'h4, 24'h000000, 1'b0);
    chk("clear", 24'h0, {22'h0, PROCESSOR_STATE_BITS[1:0]});
    for (i = 0; i < 60 && PROCESSOR_STATE_BITS[2] !== 1'b1; i = i + 1) @(posedge REF_CLK);
    repeat (20) @(posedge REF_CLK);
    #1;
    chk("timer", 24'h1, {23'h0, PROCESSOR_STATE_BITS[2]});
    end_sim;
  end
endmodule
